// File: hw/fsp_bank.sv
`timescale 1ns/1ns
`include "fsp_defs.svh"

module fsp_bank
  import fsp_pkg::*;
#(
  parameter int NUM_COPIES = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic mrw_valid,
  input wire logic mrr_valid,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mr_wdata,
  output logic mrr_ack,
  output logic [7:0] mrr_data,
  output logic [7:0] op_preamble_recovery_cfg,
  output logic [7:0] op_latency_cfg,
  output logic [7:0] op_io_drive_inversion_cfg,
  output logic [7:0] op_termination_cfg,
  output logic [7:0] op_ca_reference_cfg,
  output logic [7:0] op_dq_reference_cfg,
  output logic [7:0] op_controller_termination_cfg,
  output logic op_copy,
  output logic reference_current_mode,
  output logic switch_busy,
  output fsp_class_type switch_class
);

  localparam int NREG = 7;
  localparam int IDX_CA = 4;
  // Longest times round down, never below one cycle.
  localparam int CYC_SMALL_RAW = `FSP_T_SWITCH_SMALL_NS / `FSP_CORE_PERIOD_NS;
  localparam int CYC_MULTI_RAW = `FSP_T_SWITCH_MULTI_NS / `FSP_CORE_PERIOD_NS;
  localparam int CYC_RANGE_RAW = `FSP_T_SWITCH_RANGE_NS / `FSP_CORE_PERIOD_NS;
  localparam logic [3:0] CYC_SMALL = 4'(CYC_SMALL_RAW < 1 ? 1 : CYC_SMALL_RAW);
  localparam logic [3:0] CYC_MULTI = 4'(CYC_MULTI_RAW < 1 ? 1 : CYC_MULTI_RAW);
  localparam logic [3:0] CYC_RANGE = 4'(CYC_RANGE_RAW < 1 ? 1 : CYC_RANGE_RAW);

  // The select bits are single bits, so only two copies can be served.
  if (NUM_COPIES != 2) begin : g_copies_check
    $error("fsp_bank serves exactly two copies");
  end

  // Maps an address onto a duplicated register slot; slot NREG means none.
  function automatic logic [2:0] dup_slot(input logic [5:0] a);
    case (a)
      `FSP_ADDR_PREAMBLE_RECOVERY: dup_slot = 3'h0;
      `FSP_ADDR_LATENCY: dup_slot = 3'h1;
      `FSP_ADDR_IO_DRIVE: dup_slot = 3'h2;
      `FSP_ADDR_TERMINATION: dup_slot = 3'h3;
      `FSP_ADDR_CA_REFERENCE: dup_slot = 3'h4;
      `FSP_ADDR_DQ_REFERENCE: dup_slot = 3'h5;
      `FSP_ADDR_CTRL_TERMINATION: dup_slot = 3'h6;
      default: dup_slot = 3'h7;
    endcase
  endfunction

  // Field masks per slot keep reserved bits at zero.
  function automatic fsp_byte_type slot_mask(input logic [2:0] s);
    case (s)
      3'h0: slot_mask = `FSP_MASK_PREAMBLE_RECOVERY; // RULE7
      3'h1: slot_mask = `FSP_MASK_LATENCY; // RULE8
      3'h2: slot_mask = `FSP_MASK_IO_DRIVE; // RULE9
      3'h3: slot_mask = `FSP_MASK_TERMINATION; // RULE10
      3'h4: slot_mask = `FSP_MASK_REFERENCE; // RULE11
      3'h5: slot_mask = `FSP_MASK_REFERENCE; // RULE11
      3'h6: slot_mask = `FSP_MASK_CTRL_TERMINATION; // RULE12
      default: slot_mask = 8'h00;
    endcase
  endfunction

  // Picks the switching class from the two command reference settings.
  function automatic fsp_class_type pick_class(input fsp_byte_type a, input fsp_byte_type b);
    logic [5:0] diff;
    diff = (a[5:0] > b[5:0]) ? 6'(a[5:0] - b[5:0]) : 6'(b[5:0] - a[5:0]); // RULE18
    if (a[`FSP_REF_RANGE_BIT] != b[`FSP_REF_RANGE_BIT]) begin
      pick_class = FSP_CLASS_RANGE; // RULE17
    end else if (diff >= 6'h02) begin
      pick_class = FSP_CLASS_MULTI; // RULE16
    end else begin
      pick_class = FSP_CLASS_SMALL; // RULE16
    end
  endfunction

  function automatic logic [3:0] class_cycles(input fsp_class_type c);
    case (c)
      FSP_CLASS_MULTI: class_cycles = CYC_MULTI;
      FSP_CLASS_RANGE: class_cycles = CYC_RANGE;
      default: class_cycles = CYC_SMALL;
    endcase
  endfunction

  // ---------------- Link domain ----------------
  logic lrst_meta_q;
  logic lrst_q;
  fsp_byte_type copy_q [NUM_COPIES][NREG];
  fsp_byte_type spc_q;
  fsp_byte_type hold_q [NREG];
  logic hold_copy_q;
  logic hold_reference_current_mode_q;
  logic hold_switch_q;
  fsp_class_type hold_class_q;
  fsp_class_type pend_class_q;
  logic dirty_q;
  logic pend_switch_q;
  logic req_q;
  logic ack_q;
  logic ack_meta_q;
  logic ack_sync_q;
  logic [2:0] wslot;
  logic acc_sel;
  logic run_sel;
  logic spc_write;
  logic flip;
  logic ctrl_change;
  logic live_write;
  logic send;
  fsp_byte_type spc_new;

  // Reset is carried into the link domain through two flip-flops.
  always_ff @(posedge link_clk) begin
    lrst_meta_q <= rst;
    lrst_q <= lrst_meta_q;
  end

  assign wslot = dup_slot(mr_addr);
  assign acc_sel = spc_q[`FSP_BIT_ACCESS_SELECT];
  assign run_sel = spc_q[`FSP_BIT_OPERATE_SELECT];
  assign spc_write = mrw_valid && (mr_addr == `FSP_ADDR_SET_POINT_CTRL);
  assign spc_new = mr_wdata & `FSP_MASK_SET_POINT_CTRL;
  assign flip = spc_write && (spc_new[`FSP_BIT_OPERATE_SELECT] != run_sel);
  assign ctrl_change = spc_write && (flip ||
    (spc_new[`FSP_BIT_REF_CURRENT] != spc_q[`FSP_BIT_REF_CURRENT]));
  // Only a write into the running copy needs to reach the core side.
  assign live_write = mrw_valid && (wslot != 3'h7) && (acc_sel == run_sel); // RULE4
  assign send = dirty_q && (req_q == ack_sync_q);

  // Duplicated storage; the access bit alone steers the copy.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      for (int c = 0; c < NUM_COPIES; c++) begin
        for (int r = 0; r < NREG; r++) begin
          copy_q[c][r] <= `FSP_RESET_PARAM; // RULE21
        end
      end
    end else if (mrw_valid && (wslot != 3'h7)) begin
      copy_q[acc_sel][wslot] <= mr_wdata & slot_mask(wslot); // RULE1 RULE2 RULE6
    end
  end

  // The control register exists once and ignores the access bit.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      spc_q <= `FSP_RESET_SET_POINT_CTRL; // RULE21
    end else if (spc_write) begin
      spc_q <= spc_new; // RULE23 RULE6
    end
  end

  // Mode register reads answer one link cycle later.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      mrr_ack <= 1'b0;
      mrr_data <= 8'h00;
    end else begin
      mrr_ack <= mrr_valid;
      if (mrr_valid) begin
        if (wslot != 3'h7) begin
          mrr_data <= copy_q[acc_sel][wslot]; // RULE2
        end else if (mr_addr == `FSP_ADDR_SET_POINT_CTRL) begin
          mrr_data <= spc_q; // RULE23
        end else begin
          mrr_data <= 8'h00;
        end
      end
    end
  end

  // Pending update tracking; a new event in the send cycle is kept.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      dirty_q <= 1'b0;
      pend_switch_q <= 1'b0;
      pend_class_q <= FSP_CLASS_SMALL;
    end else begin
      dirty_q <= live_write || ctrl_change || (dirty_q && !send);
      pend_switch_q <= flip || (pend_switch_q && !send);
      if (flip) begin
        pend_class_q <= pick_class(copy_q[0][IDX_CA], copy_q[1][IDX_CA]); // RULE16 RULE17
      end
    end
  end

  // Snapshot of the running copy, stable until the core acknowledges it.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      for (int r = 0; r < NREG; r++) begin
        hold_q[r] <= `FSP_RESET_PARAM;
      end
      hold_copy_q <= 1'b0;
      hold_reference_current_mode_q <= 1'b0;
      hold_switch_q <= 1'b0;
      hold_class_q <= FSP_CLASS_SMALL;
      req_q <= 1'b0;
    end else if (send) begin
      for (int r = 0; r < NREG; r++) begin
        hold_q[r] <= copy_q[run_sel][r]; // RULE3 RULE5
      end
      hold_copy_q <= run_sel;
      hold_reference_current_mode_q <= spc_q[`FSP_BIT_REF_CURRENT];
      hold_switch_q <= pend_switch_q;
      hold_class_q <= pend_class_q;
      req_q <= ~req_q;
    end
  end

  // Acknowledge toggle back from the core domain.
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  // ---------------- Core domain ----------------
  logic req_meta_q;
  logic req_sync_q;
  logic take;
  fsp_byte_type act_q [NREG];
  fsp_state_type state_q;
  logic [3:0] timer_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= req_q;
      req_sync_q <= req_meta_q;
    end
  end

  // The hold registers are quiet whenever the toggles differ.
  assign take = req_sync_q != ack_q;

  // All running parameters are loaded in one edge, never piecemeal.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int r = 0; r < NREG; r++) begin
        act_q[r] <= `FSP_RESET_PARAM;
      end
      op_copy <= 1'b0; // RULE21
      reference_current_mode <= 1'b0;
      ack_q <= 1'b0;
    end else if (take) begin
      for (int r = 0; r < NREG; r++) begin
        act_q[r] <= hold_q[r]; // RULE5
      end
      op_copy <= hold_copy_q; // RULE3
      reference_current_mode <= hold_reference_current_mode_q;
      ack_q <= req_sync_q;
    end
  end

  // Switch timer marks the window in which the controller must stay quiet.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= FSP_IDLE;
      timer_q <= 4'h0;
      switch_class <= FSP_CLASS_SMALL;
    end else begin
      case (state_q)
        FSP_IDLE: begin
          if (take && hold_switch_q) begin
            state_q <= FSP_SWITCH;
            timer_q <= class_cycles(hold_class_q) - 4'h1; // RULE5
            switch_class <= hold_class_q;
          end
        end
        FSP_SWITCH: begin
          if (timer_q == 4'h0) begin
            state_q <= FSP_IDLE;
          end else begin
            timer_q <= timer_q - 4'h1;
          end
        end
        default: state_q <= FSP_IDLE;
      endcase
    end
  end

  assign switch_busy = state_q == FSP_SWITCH;
  assign op_preamble_recovery_cfg = act_q[0];
  assign op_latency_cfg = act_q[1];
  assign op_io_drive_inversion_cfg = act_q[2];
  assign op_termination_cfg = act_q[3];
  assign op_ca_reference_cfg = act_q[4];
  assign op_dq_reference_cfg = act_q[5];
  assign op_controller_termination_cfg = act_q[6];

  // ---------------- Checks ----------------
  logic [3:0] busy_len_q;

  // Length of the current busy window, for the busy bound check.
  always_ff @(posedge core_clk) begin
    if (rst || !switch_busy) begin
      busy_len_q <= 4'h0;
    end else begin
      busy_len_q <= busy_len_q + 4'h1;
    end
  end

  property p_write_access_copy;
    @(posedge link_clk) disable iff (lrst_q)
      (mrw_valid && wslot == 3'h1) |=>
        copy_q[$past(acc_sel)][1] == ($past(mr_wdata) & `FSP_MASK_LATENCY);
  endproperty
  a_write_access_copy: assert property (p_write_access_copy) // RULE2
    else $error("latency write missed the access-selected copy");

  property p_read_access_copy;
    @(posedge link_clk) disable iff (lrst_q)
      (mrr_valid && !mrw_valid && wslot == 3'h4) |=>
        mrr_ack && mrr_data == $past(copy_q[acc_sel][4]);
  endproperty
  a_read_access_copy: assert property (p_read_access_copy) // RULE2
    else $error("reference read returned the wrong copy");

  property p_idle_copy_quiet;
    @(posedge link_clk) disable iff (lrst_q)
      (mrw_valid && wslot != 3'h7 && acc_sel != run_sel && !dirty_q) |=> !dirty_q;
  endproperty
  a_idle_copy_quiet: assert property (p_idle_copy_quiet) // RULE4
    else $error("write to idle copy disturbed operation");

  property p_single_copy_ctrl;
    @(posedge link_clk) disable iff (lrst_q)
      spc_write |=> spc_q == $past(spc_new);
  endproperty
  a_single_copy_ctrl: assert property (p_single_copy_ctrl) // RULE23
    else $error("control register write lost");

  property p_range_class;
    @(posedge link_clk) disable iff (lrst_q)
      (flip && copy_q[0][4][6] != copy_q[1][4][6]) |=> pend_class_q == FSP_CLASS_RANGE;
  endproperty
  a_range_class: assert property (p_range_class) // RULE17
    else $error("range change did not select the long class");

  property p_step_class;
    @(posedge link_clk) disable iff (lrst_q)
      (flip && copy_q[0][4][6] == copy_q[1][4][6] &&
       copy_q[0][4][5:0] != copy_q[1][4][5:0]) |=>
        pend_class_q == (($past(copy_q[0][4][5:0]) + 7'h01 == $past(copy_q[1][4][5:0])) ||
        ($past(copy_q[1][4][5:0]) + 7'h01 == $past(copy_q[0][4][5:0])) ?
        FSP_CLASS_SMALL : FSP_CLASS_MULTI);
  endproperty
  a_step_class: assert property (p_step_class) // RULE16 RULE18
    else $error("step size mapped to the wrong class");

  sequence s_switch_taken;
    take && hold_switch_q && !switch_busy;
  endsequence

  sequence s_switch_window;
    switch_busy[*2] ##1 !switch_busy;
  endsequence

  property p_switch_window;
    @(posedge core_clk) disable iff (rst)
      s_switch_taken |=> s_switch_window;
  endproperty
  a_switch_window: assert property (p_switch_window) // RULE5
    else $error("switch window length is wrong");

  property p_atomic_apply;
    @(posedge core_clk) disable iff (rst)
      $changed(op_copy) |-> $past(take) && op_latency_cfg == $past(hold_q[1]) &&
        op_ca_reference_cfg == $past(hold_q[4]);
  endproperty
  a_atomic_apply: assert property (p_atomic_apply) // RULE3 RULE5
    else $error("operating copy changed without a full parameter load");

  property p_busy_bound;
    @(posedge core_clk) disable iff (rst)
      switch_busy |-> busy_len_q < CYC_RANGE;
  endproperty
  a_busy_bound: assert property (p_busy_bound) // RULE5
    else $error("switch outlasted the longest switching time");

endmodule

// File: hw/fsp_defs.svh
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// Notes on behaviour
// [RULE1] Two copies behind shared mode register addresses.
// [RULE2] Access bit picks copy for writes, reads.
// [RULE3] Operate bit picks copy the device runs.
// [RULE4] Writing idle copy leaves operation untouched.
// [RULE5] New copy applied whole within switch time.
// [RULE6] Access and operate bits fully independent.
// [RULE7] Preamble/recovery register duplicated field layout.
// [RULE8] Latency register duplicated field layout.
// [RULE9] I/O register duplicated field layout.
// [RULE10] Termination register duplicated field layout.
// [RULE11] Reference registers: 6-bit setting plus range.
// [RULE12] Controller termination register duplicated field layout.
// [RULE13] Controller matches pull-up point across channels.
// [RULE14] Controller sets fast reference current during switch.
// [RULE15] Controller waits switch time before next command.
// [RULE16] Same range: one step short, more middle.
// [RULE17] Range differs between copies: long class.
// [RULE18] Class selection symmetric in both directions.
// [RULE19] Controller keeps clock valid after switch write.
// [RULE20] Controller gives valid clock before next command.
// [RULE21] Power-up runs copy 0, unterminated defaults.
// [RULE22] Trained copies swapped by single write.
// [RULE23] Single-copy registers ignore the access bit.

// Mode register addresses.
`define FSP_ADDR_PREAMBLE_RECOVERY 6'h01
`define FSP_ADDR_LATENCY 6'h02
`define FSP_ADDR_IO_DRIVE 6'h03
`define FSP_ADDR_TERMINATION 6'h0b
`define FSP_ADDR_CA_REFERENCE 6'h0c
`define FSP_ADDR_SET_POINT_CTRL 6'h0d
`define FSP_ADDR_DQ_REFERENCE 6'h0e
`define FSP_ADDR_CTRL_TERMINATION 6'h16

// Writable field masks; other bits read as zero.
`define FSP_MASK_PREAMBLE_RECOVERY 8'hfc
`define FSP_MASK_LATENCY 8'h7f
`define FSP_MASK_IO_DRIVE 8'hfb
`define FSP_MASK_TERMINATION 8'h77
`define FSP_MASK_REFERENCE 8'h7f
`define FSP_MASK_CTRL_TERMINATION 8'h3f
`define FSP_MASK_SET_POINT_CTRL 8'hc8

// Field positions.
`define FSP_BIT_ACCESS_SELECT 6
`define FSP_BIT_OPERATE_SELECT 7
`define FSP_BIT_REF_CURRENT 3
`define FSP_REF_RANGE_BIT 6
`define FSP_REF_SETTING_MSB 5

// Reset values: unterminated low-frequency settings.
`define FSP_RESET_PARAM 8'h00
`define FSP_RESET_SET_POINT_CTRL 8'h00

// Timing.
`define FSP_CORE_PERIOD_NS 100
`define FSP_T_SWITCH_SMALL_NS 200
`define FSP_T_SWITCH_MULTI_NS 200
`define FSP_T_SWITCH_RANGE_NS 250
`endif

// File: hw/fsp_pkg.sv
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_CLASS_SMALL,
    FSP_CLASS_MULTI,
    FSP_CLASS_RANGE
  } fsp_class_type;

  typedef enum logic {
    FSP_IDLE,
    FSP_SWITCH
  } fsp_state_type;

  typedef logic [7:0] fsp_byte_type;
endpackage

// File: verif/fsp_ctrl_model.sv
`timescale 1ns/1ns

module fsp_ctrl_model (
  input wire logic link_clk,
  output logic mrw_valid,
  output logic mrr_valid,
  output logic [5:0] mr_addr,
  output logic [7:0] mr_wdata,
  input wire logic mrr_ack,
  input wire logic [7:0] mrr_data
);
  // The command clock runs without pause, so it is valid around every switch.
  // Single channel, so the pull-up point matches across channels trivially.
  initial begin
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mr_addr = 6'h3f;
    mr_wdata = 8'h00;
  end

  // A write is held over one taken edge; the idle bus then shows the inverse.
  // Inverting stops a stale address or data value from passing for a live one.
  task automatic mr_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge link_clk);
    #2;
    mrw_valid = 1'b1;
    mr_addr = a;
    mr_wdata = d;
    @(posedge link_clk);
    #2;
    mrw_valid = 1'b0;
    mr_addr = ~a;
    mr_wdata = ~d;
  endtask

  // A read is taken at one edge and answered for one cycle; no answer leaves unknown data.
  task automatic mr_read(input logic [5:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge link_clk);
    #2;
    mrr_valid = 1'b1;
    mr_addr = a;
    @(posedge link_clk);
    #2;
    mrr_valid = 1'b0;
    mr_addr = ~a;
    // The answer stands only until the next edge, so it is taken now.
    if (mrr_ack === 1'b1) begin
      d = mrr_data;
    end
  endtask
endmodule

// File: verif/tb_frequency_set_point_bank.sv
`timescale 1ns/1ns
`include "fsp_defs.svh"

module tb_frequency_set_point_bank;
  import fsp_pkg::*;
  logic core_clk, link_clk, rst, mrw_valid, mrr_valid, mrr_ack;
  logic op_copy, ref_mode, busy;
  logic [5:0] mr_addr;
  logic [7:0] mr_wdata, mrr_data;
  logic [7:0] op_b [7];
  fsp_class_type cls;
  int error_cnt = 0;
  int check_count = 0;
  logic [5:0] addr_t [7] = '{`FSP_ADDR_PREAMBLE_RECOVERY, `FSP_ADDR_LATENCY,
    `FSP_ADDR_IO_DRIVE, `FSP_ADDR_TERMINATION, `FSP_ADDR_CA_REFERENCE,
    `FSP_ADDR_DQ_REFERENCE, `FSP_ADDR_CTRL_TERMINATION};
  logic [7:0] mask_t [7] = '{`FSP_MASK_PREAMBLE_RECOVERY, `FSP_MASK_LATENCY,
    `FSP_MASK_IO_DRIVE, `FSP_MASK_TERMINATION, `FSP_MASK_REFERENCE,
    `FSP_MASK_REFERENCE, `FSP_MASK_CTRL_TERMINATION};
  logic [7:0] exp0 [7];
  logic [7:0] exp1 [7];
  logic cur;

  fsp_bank u_fsp_bank (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
    .mrr_ack(mrr_ack), .mrr_data(mrr_data), .op_preamble_recovery_cfg(op_b[0]),
    .op_latency_cfg(op_b[1]), .op_io_drive_inversion_cfg(op_b[2]),
    .op_termination_cfg(op_b[3]), .op_ca_reference_cfg(op_b[4]),
    .op_dq_reference_cfg(op_b[5]), .op_controller_termination_cfg(op_b[6]),
    .op_copy(op_copy), .reference_current_mode(ref_mode), .switch_busy(busy),
    .switch_class(cls));

  fsp_ctrl_model u_fsp_ctrl_model (.link_clk(link_clk), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
    .mrr_ack(mrr_ack), .mrr_data(mrr_data));

  // Core clock at 100 ns.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Link clock at 32 ns, offset so its edges drift against the core clock.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask

  task automatic chk_class(input fsp_class_type g, input fsp_class_type e);
    chk_byte({6'h00, g}, {6'h00, e});
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_fsp_ctrl_model.mr_read(a, d);
    chk_byte(d, e);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_fsp_ctrl_model.mr_write(a, d);
  endtask

  // Running outputs are compared as a whole set against one copy.
  task automatic chk_ops(input logic sel);
    for (int i = 0; i < 7; i++) chk_byte(op_b[i], sel ? exp1[i] : exp0[i]);
  endtask

  // Updates cross in a link cycle plus a few core cycles; ten is ample.
  task automatic settle();
    repeat (10) @(posedge core_clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      exp0[i] = 8'h00;
      rd_chk(addr_t[i], 8'h00);
    end
    rd_chk(`FSP_ADDR_SET_POINT_CTRL, 8'h00);
    chk_ops(1'b0);
    chk_bit(op_copy, 1'b0);
    chk_bit(busy, 1'b0);
  endtask

  task automatic t_copy0();
    for (int i = 0; i < 7; i++) begin
      wr(addr_t[i], 8'hff);
      exp0[i] = mask_t[i];
      rd_chk(addr_t[i], mask_t[i]);
    end
    wr(6'h05, 8'hff);
    rd_chk(6'h05, 8'h00);
    settle();
    chk_ops(1'b0);
  endtask

  task automatic t_copy1();
    wr(`FSP_ADDR_SET_POINT_CTRL, 8'h40);
    rd_chk(`FSP_ADDR_CA_REFERENCE, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(addr_t[i], 8'h55);
      exp1[i] = 8'h55 & mask_t[i];
      rd_chk(addr_t[i], exp1[i]);
    end
    rd_chk(`FSP_ADDR_SET_POINT_CTRL, 8'h40);
    settle();
    chk_ops(1'b0);
    chk_bit(op_copy, 1'b0);
    wr(`FSP_ADDR_SET_POINT_CTRL, 8'h00);
    rd_chk(`FSP_ADDR_LATENCY, exp0[1]);
    rd_chk(`FSP_ADDR_SET_POINT_CTRL, 8'h00);
  endtask

  // Each case loads both reference settings, then flips the operating copy.
  task automatic t_switch();
    logic [7:0] c0 [4] = '{8'h0c, 8'h0c, 8'h0c, 8'h0e};
    logic [7:0] c1 [4] = '{8'h0d, 8'h0e, 8'h4c, 8'h0d};
    fsp_class_type ec [4] = '{FSP_CLASS_SMALL, FSP_CLASS_MULTI, FSP_CLASS_RANGE,
      FSP_CLASS_SMALL};
    int n;
    cur = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(`FSP_ADDR_SET_POINT_CTRL, {cur, 7'h00});
      wr(`FSP_ADDR_CA_REFERENCE, c0[k]);
      wr(`FSP_ADDR_SET_POINT_CTRL, {cur, 7'h40});
      wr(`FSP_ADDR_CA_REFERENCE, c1[k]);
      exp0[4] = c0[k];
      exp1[4] = c1[k];
      settle();
      wr(`FSP_ADDR_SET_POINT_CTRL, {~cur, 7'h48});
      n = 0;
      while (busy !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      chk_ops(~cur);
      chk_bit(op_copy, ~cur);
      chk_class(cls, ec[k]);
      chk_bit(ref_mode, 1'b1);
      n = 0;
      while (busy === 1'b1 && n < 8) begin
        @(negedge core_clk);
        n++;
      end
      chk_byte(8'(n), 8'h02);
      repeat (3) @(posedge core_clk);
      wr(`FSP_ADDR_SET_POINT_CTRL, {~cur, 7'h40});
      settle();
      chk_bit(ref_mode, 1'b0);
      cur = ~cur;
    end
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole run needs well under a millisecond; twice that means a hang.
  initial begin
    #2000000;
    error_cnt++;
    results();
  end

  initial begin
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    #2;
    rst = 1'b0;
    repeat (6) @(posedge link_clk);
    t_reset();
    t_copy0();
    t_copy1();
    t_switch();
    results();
  end
endmodule
